// ---- include/ppc_pkg.sv ----
// Shared constants and types of the parallel port controller
// ============================================================
// Overview of operation
// - The port runs compatibility, nibble, byte, EPP and ECP transfers to and from the peripheral.
// - A FIFO-backed port mode and a test mode that exercises the FIFO without handshake are provided.
// - Registers are decoded only in I/O space, fully qualified or aliased.
// - The DMA channel is an 8-bit slave that works with ISA compatible timing.
// - The interrupt output is active high and signals a request by a rising edge.
// - Writing a peripheral address to the EPP address port starts an EPP address cycle.
// - An access to EPP data port 0 moves bits 7-0 of the 32-bit word.
// - An access to EPP data port 1 moves bits 15-8 of the 32-bit word.
// - An access to EPP data port 2 moves bits 23-16 of the 32-bit word.
// - An access to EPP data port 3 moves bits 31-24 of the 32-bit word.
// - Demand-mode DMA is supported and is enabled at reset.
// - Port outputs can float while the port is disabled, and come up configured that way.
package ppc_pkg;

  // ============================================================
  // Bus geometry
  localparam int AW = 12;
  localparam int DW = 32;

  // ============================================================
  // Register byte offsets
  localparam logic [7:0] OFS_DATA  = 8'h00;
  localparam logic [7:0] OFS_STAT  = 8'h04;
  localparam logic [7:0] OFS_CTRL  = 8'h08;
  localparam logic [7:0] OFS_EPPA  = 8'h0C;
  localparam logic [7:0] OFS_EPPD0 = 8'h10;
  localparam logic [7:0] OFS_EPPD3 = 8'h1C;
  localparam logic [7:0] OFS_AFIFO = 8'h20;
  localparam logic [7:0] OFS_FIFO  = 8'h24;
  localparam logic [7:0] OFS_ECR   = 8'h28;
  localparam logic [7:0] OFS_CFG   = 8'h2C;
  localparam logic [7:0] OFS_ISTAT = 8'h30;
  localparam logic [7:0] OFS_IEN   = 8'h34;
  localparam logic [7:0] OFS_ICLR  = 8'h38;

  // ============================================================
  // Configuration bits and reset values
  localparam int CFG_PORT_EN = 0;
  localparam int CFG_FLOAT   = 1;
  localparam int CFG_ALIAS   = 2;
  localparam int CFG_DMA_EN  = 3;
  localparam int CFG_DEMAND  = 4;
  localparam int CFG_ECP_EN  = 5;
  localparam int CFG_EPP_EN  = 6;
  localparam logic [6:0] CFG_RST  = 7'h7B;
  localparam logic [5:0] CTRL_RST = 6'h04;
  localparam int CTRL_DIR = 5;

  // Interrupt event bits
  localparam int EV_ACK   = 0;
  localparam int EV_EMPTY = 1;
  localparam int EV_DONE  = 2;
  localparam int EV_TMO   = 3;

  // ============================================================
  // Timing
  localparam int CLK_NS   = 10;
  localparam int SETUP_NS = 500;
  localparam int STB_NS   = 500;
  localparam int TMO_NS   = 10000;
  localparam logic [9:0] SETUP_CYC = 10'((SETUP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [9:0] STB_CYC   = 10'((STB_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [9:0] TMO_CYC   = 10'(TMO_NS / CLK_NS);

  // FIFO shape
  localparam int FIFO_W = 9;
  localparam int FIFO_D = 16;

  // ============================================================
  // Types
  typedef enum logic [2:0] {
    MODE_STD   = 3'b000,
    MODE_BYTE  = 3'b001,
    MODE_PFIFO = 3'b010,
    MODE_ECP   = 3'b011,
    MODE_EPP   = 3'b100,
    MODE_TEST  = 3'b110
  } ppc_mode_t;

  typedef enum logic [1:0] {
    ENG_IDLE  = 2'b00,
    ENG_SETUP = 2'b01,
    ENG_STRB  = 2'b10,
    ENG_HOLD  = 2'b11
  } ppc_eng_t;

  typedef enum logic [1:0] {
    K_EPPA = 2'b00,
    K_EPPD = 2'b01,
    K_COMP = 2'b10,
    K_ECP  = 2'b11
  } ppc_kind_t;

endpackage

// ---- rtl/ppc_fifo.sv ----
// Byte FIFO between the bus side and the port engine
`timescale 1ns/1ps
module ppc_fifo #(
  parameter int W = ppc_pkg::FIFO_W,
  parameter int D = ppc_pkg::FIFO_D
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AB = $clog2(D);

  logic [W-1:0] mem [D];
  logic [AB:0]  wr_ptr_reg;
  logic [AB:0]  rd_ptr_reg;

  // Full when pointers differ only in the wrap bit
  assign in_ready  = !((wr_ptr_reg[AB] != rd_ptr_reg[AB]) && (wr_ptr_reg[AB-1:0] == rd_ptr_reg[AB-1:0]));
  assign out_valid = (wr_ptr_reg != rd_ptr_reg);
  assign out_data  = mem[rd_ptr_reg[AB-1:0]];

  // Storage has no reset; only the pointers define contents
  always_ff @(posedge pclk) begin
    if (in_valid && in_ready) begin
      mem[wr_ptr_reg[AB-1:0]] <= in_data;
    end
  end

  // Pointers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (in_valid && in_ready) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (out_valid && out_ready) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end
endmodule

// ---- rtl/ppc_top.sv ----
// Parallel port controller: APB registers, DMA slave, port engine and pins
//
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
module ppc_top (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [ppc_pkg::AW-1:0] paddr,
  input  wire logic [ppc_pkg::DW-1:0] pwdata,
  output logic [ppc_pkg::DW-1:0]      prdata,
  output logic                        pready,
  output logic                        pslverr,
  output logic                        irq,
  output logic                        dma_req,
  input  wire logic                   dma_ack,
  input  wire logic [7:0]             dma_wdata,
  input  wire logic [7:0]             pd_in,
  output logic [7:0]                  pd_out,
  output logic                        pd_oe_n,
  output logic                        strobe_n,
  output logic                        autofd_n,
  output logic                        init_n,
  output logic                        selin_n,
  output logic                        ctl_oe_n,
  input  wire logic                   ack_n,
  input  wire logic                   busy,
  input  wire logic                   perror,
  input  wire logic                   select,
  input  wire logic                   fault_n
);
  import ppc_pkg::*;

  // ============================================================
  // Declarations
  logic [21:0]      sync1_reg;
  logic [21:0]      sync2_reg;
  logic             ack_d_reg;
  logic             dack_d_reg;
  logic             empty_d_reg;
  logic [7:0]       data_reg;
  logic [5:0]       ctrl_reg;
  ppc_mode_t        mode_reg;
  logic [6:0]       cfg_reg;
  logic [3:0]       ien_reg;
  logic [3:0]       istat_reg;
  logic [3:0]       istat_next;
  logic             launched_reg;
  ppc_eng_t         eng_state_reg;
  ppc_kind_t        eng_kind_reg;
  logic             eng_read_reg;
  logic             eng_cmd_reg;
  logic [7:0]       eng_byte_reg;
  logic [7:0]       eng_rdata_reg;
  logic [9:0]       eng_cnt_reg;
  logic             eng_done_reg;
  logic             eng_tmo_reg;
  logic             s_dack;
  logic             s_busy;
  logic             s_ack_n;
  logic             s_pe;
  logic             s_slct;
  logic             s_fault_n;
  logic [7:0]       s_pd;
  logic [7:0]       s_dma;
  logic [7:0]       ofs;
  logic             hit;
  logic             apb_acc;
  logic             wr_fire;
  logic             is_epp;
  logic [1:0]       lane;
  logic [7:0]       lane_byte;
  logic             epp_ok;
  logic             epp_go;
  logic             fifo_mode;
  logic             fifo_go;
  logic             is_push;
  logic             apb_push;
  logic             dack_rise;
  logic             dma_push;
  logic             test_pop;
  logic             fifo_in_valid;
  logic             fifo_in_ready;
  logic [8:0]       fifo_in_data;
  logic             fifo_out_valid;
  logic [8:0]       fifo_out_data;
  logic             eng_epp;
  logic             tmo_hit;
  logic             flt;
  logic [3:0]       ev;
  logic [DW-1:0]    rd_val;

  // ============================================================
  // Pin synchronisers: every pin input passes two flops first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= 22'h00000B; // Idle pin levels, so no false ack edge follows reset
      sync2_reg <= 22'h00000B;
    end else begin
      sync1_reg <= {dma_wdata, pd_in, dma_ack, busy, ack_n, perror, select, fault_n};
      sync2_reg <= sync1_reg;
    end
  end

  assign s_fault_n = sync2_reg[0];
  assign s_slct    = sync2_reg[1];
  assign s_pe      = sync2_reg[2];
  assign s_ack_n   = sync2_reg[3];
  assign s_busy    = sync2_reg[4];
  assign s_dack    = sync2_reg[5];
  assign s_pd      = sync2_reg[13:6];
  assign s_dma     = sync2_reg[21:14];

  // Edge history of ack and dack taken from the synchronised copies only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_d_reg   <= 1'b1;
      dack_d_reg  <= 1'b0;
      empty_d_reg <= 1'b1;
    end else begin
      ack_d_reg   <= s_ack_n;
      dack_d_reg  <= s_dack;
      empty_d_reg <= !fifo_out_valid;
    end
  end

  // ============================================================
  // Address decode
  // I/O decode, full or aliased
  assign ofs = paddr[7:0];
  assign hit = cfg_reg[CFG_ALIAS] || (paddr[AW-1:8] == '0);

  assign apb_acc   = psel && penable && !pready;
  assign wr_fire   = psel && penable && pready && pwrite && hit;
  assign is_epp    = hit && (ofs >= OFS_EPPA) && (ofs <= OFS_EPPD3) && (ofs[1:0] == 2'b00);
  assign lane      = ofs[3:2];
  assign lane_byte = pwdata[{lane, 3'b000} +: 8];
  assign epp_ok    = (mode_reg == MODE_EPP) && cfg_reg[CFG_EPP_EN];
  assign fifo_mode = (mode_reg == MODE_PFIFO) || ((mode_reg == MODE_ECP) && cfg_reg[CFG_ECP_EN]);
  assign flt       = !cfg_reg[CFG_PORT_EN] && cfg_reg[CFG_FLOAT];

  // ============================================================
  // FIFO feed: bus writes have priority, DMA fills the gaps
  // FIFO filled in FIFO, ECP and test modes
  assign is_push   = hit && pwrite && (fifo_mode || (mode_reg == MODE_TEST))
                     && ((ofs == OFS_FIFO) || ((ofs == OFS_AFIFO) && (mode_reg == MODE_ECP)));
  assign apb_push  = wr_fire && is_push;
  assign dack_rise = s_dack && !dack_d_reg;
  assign dma_push  = dack_rise && fifo_mode && !(psel && is_push) && fifo_in_ready;
  assign fifo_in_valid = apb_push || dma_push;
  assign fifo_in_data  = apb_push ? {(ofs == OFS_AFIFO), pwdata[7:0]} : {1'b0, s_dma};
  // Test mode drains by bus reads, no handshake
  assign test_pop  = psel && penable && pready && !pwrite && hit
                     && (ofs == OFS_FIFO) && (mode_reg == MODE_TEST);

  ppc_fifo u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_go || test_pop),
    .out_data  (fifo_out_data)
  );

  // ============================================================
  // Engine launch terms
  assign epp_go  = apb_acc && is_epp && epp_ok && !launched_reg && (eng_state_reg == ENG_IDLE);
  // Queued bytes leave on their own
  assign fifo_go = (eng_state_reg == ENG_IDLE) && !epp_go && fifo_mode && fifo_out_valid;
  assign eng_epp = (eng_kind_reg == K_EPPA) || (eng_kind_reg == K_EPPD);
  // Only EPP cycles time out; a busy printer may stall for ever
  assign tmo_hit = eng_epp && (eng_cnt_reg == TMO_CYC);

  // ============================================================
  // Port engine: setup, strobe, hold for every hardware cycle
  // EPP and ECP cycles driven by hardware
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eng_state_reg <= ENG_IDLE;
      eng_kind_reg  <= K_COMP;
      eng_read_reg  <= 1'b0;
      eng_cmd_reg   <= 1'b0;
      eng_byte_reg  <= 8'h00;
      eng_rdata_reg <= 8'h00;
      eng_cnt_reg   <= 10'h000;
      eng_done_reg  <= 1'b0;
      eng_tmo_reg   <= 1'b0;
    end else begin
      eng_done_reg <= 1'b0;
      eng_cnt_reg  <= eng_cnt_reg + 10'h001;
      unique case (eng_state_reg)
        ENG_IDLE: begin
          eng_cnt_reg <= 10'h000;
          if (epp_go) begin
            // Address port starts an address cycle
            // Data port k carries byte k
            eng_kind_reg  <= (ofs == OFS_EPPA) ? K_EPPA : K_EPPD;
            eng_read_reg  <= !pwrite;
            eng_byte_reg  <= (ofs == OFS_EPPA) ? pwdata[7:0] : lane_byte;
            eng_cmd_reg   <= 1'b0;
            eng_state_reg <= ENG_SETUP;
          end else if (fifo_go) begin
            eng_kind_reg  <= (mode_reg == MODE_ECP) ? K_ECP : K_COMP;
            eng_read_reg  <= 1'b0;
            eng_byte_reg  <= fifo_out_data[7:0];
            eng_cmd_reg   <= fifo_out_data[8];
            eng_state_reg <= ENG_SETUP;
          end
        end
        ENG_SETUP: begin
          // Data settles; compatibility and ECP cycles also wait for busy low
          if (tmo_hit) begin
            eng_state_reg <= ENG_IDLE;
            eng_done_reg  <= 1'b1;
            eng_tmo_reg   <= 1'b1;
          end else if ((eng_cnt_reg >= SETUP_CYC) && (eng_epp || !s_busy)) begin
            eng_state_reg <= ENG_STRB;
            eng_cnt_reg   <= 10'h000;
          end
        end
        ENG_STRB: begin
          // Compatibility strobe is a fixed width pulse
          if (tmo_hit) begin
            eng_state_reg <= ENG_IDLE;
            eng_done_reg  <= 1'b1;
            eng_tmo_reg   <= 1'b1;
          end else if ((eng_cnt_reg >= STB_CYC) && ((eng_kind_reg == K_COMP) || s_busy)) begin
            eng_rdata_reg <= s_pd;
            eng_state_reg <= ENG_HOLD;
            eng_cnt_reg   <= 10'h000;
          end
        end
        ENG_HOLD: begin
          // Interlocked modes wait for the peripheral to release
          if (tmo_hit) begin
            eng_state_reg <= ENG_IDLE;
            eng_done_reg  <= 1'b1;
            eng_tmo_reg   <= 1'b1;
          end else if ((eng_cnt_reg >= STB_CYC) && ((eng_kind_reg == K_COMP) || !s_busy)) begin
            eng_state_reg <= ENG_IDLE;
            eng_done_reg  <= 1'b1;
            eng_tmo_reg   <= 1'b0;
          end
        end
      endcase
    end
  end

  // ============================================================
  // Pin drivers, all registered
  // Everything floats while the port is off and CFG_FLOAT is set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pd_out   <= 8'h00;
      pd_oe_n  <= 1'b1;
      strobe_n <= 1'b1;
      autofd_n <= 1'b1;
      init_n   <= 1'b1;
      selin_n  <= 1'b1;
      ctl_oe_n <= 1'b1;
    end else begin
      ctl_oe_n <= flt;
      init_n   <= ctrl_reg[2];
      if (eng_state_reg != ENG_IDLE) begin
        pd_out   <= eng_byte_reg;
        pd_oe_n  <= flt || eng_read_reg;
        strobe_n <= eng_epp ? eng_read_reg : (eng_state_reg != ENG_STRB);
        autofd_n <= (eng_kind_reg == K_EPPD) ? (eng_state_reg != ENG_STRB)
                                             : !((eng_kind_reg == K_ECP) && eng_cmd_reg);
        selin_n  <= !((eng_kind_reg == K_EPPA) && (eng_state_reg == ENG_STRB));
      end else begin
        // Software-timed compatibility, nibble and byte modes
        pd_out   <= data_reg;
        pd_oe_n  <= flt || ((mode_reg != MODE_STD) && ctrl_reg[CTRL_DIR]);
        strobe_n <= !ctrl_reg[0];
        autofd_n <= !ctrl_reg[1];
        selin_n  <= !ctrl_reg[3];
      end
    end
  end

  // ============================================================
  // Software registers, written at the completing APB edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_reg <= 8'h00;
      ctrl_reg <= CTRL_RST;
      mode_reg <= MODE_STD;
      cfg_reg  <= CFG_RST;
      ien_reg  <= 4'h0;
    end else if (wr_fire) begin
      if (ofs == OFS_DATA) begin
        data_reg <= pwdata[7:0];
      end
      if (ofs == OFS_CTRL) begin
        ctrl_reg <= pwdata[5:0];
      end
      if (ofs == OFS_ECR) begin
        mode_reg <= ppc_mode_t'(pwdata[7:5]);
      end
      if (ofs == OFS_CFG) begin
        cfg_reg <= pwdata[6:0];
      end
      if (ofs == OFS_IEN) begin
        ien_reg <= pwdata[3:0];
      end
    end
  end

  // ============================================================
  // Interrupt status: a new event beats a clear in the same cycle
  assign ev[EV_ACK]   = ack_d_reg && !s_ack_n;
  assign ev[EV_EMPTY] = fifo_mode && !fifo_out_valid && !empty_d_reg;
  assign ev[EV_DONE]  = eng_done_reg;
  assign ev[EV_TMO]   = eng_done_reg && eng_tmo_reg;

  always_comb begin
    istat_next = istat_reg | ev;
    if (wr_fire && (ofs == OFS_ICLR)) begin
      istat_next = (istat_reg & ~pwdata[3:0]) | ev;
    end
  end

  // Level high while enabled, so a request shows as a rising edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      istat_reg <= 4'h0;
      irq       <= 1'b0;
    end else begin
      istat_reg <= istat_next;
      irq       <= |(istat_next & ien_reg);
    end
  end

  // ============================================================
  // Demand DMA request: held while the FIFO has room
  // Demand mode keeps the request up between bytes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_req <= 1'b0;
    end else begin
      dma_req <= cfg_reg[CFG_DMA_EN] && cfg_reg[CFG_DEMAND] && fifo_mode && fifo_in_ready;
    end
  end

  // ============================================================
  // Read mux
  always_comb begin
    rd_val = '0;
    if (hit) begin
      unique case (ofs)
        OFS_DATA:  rd_val[7:0] = data_reg;
        OFS_STAT:  rd_val[7:0] = {!s_busy, s_ack_n, s_pe, s_slct, s_fault_n, 2'b00, istat_reg[EV_TMO]};
        OFS_CTRL:  rd_val[5:0] = ctrl_reg;
        OFS_FIFO:  rd_val[7:0] = fifo_out_valid ? fifo_out_data[7:0] : 8'h00;
        OFS_ECR:   rd_val[7:0] = {mode_reg, 3'b000, !fifo_in_ready, !fifo_out_valid};
        OFS_CFG:   rd_val[6:0] = cfg_reg;
        OFS_ISTAT: rd_val[3:0] = istat_reg;
        OFS_IEN:   rd_val[3:0] = ien_reg;
        default:   rd_val = '0;
      endcase
    end
  end

  // ============================================================
  // APB answer: one wait state, EPP ports wait for the engine,
  // FIFO writes wait for room so the master feels back-pressure
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready       <= 1'b0;
      pslverr      <= 1'b0;
      prdata       <= '0;
      launched_reg <= 1'b0;
    end else if (pready) begin
      pready       <= 1'b0;
      pslverr      <= 1'b0;
      launched_reg <= 1'b0;
    end else if (apb_acc) begin
      if (is_epp && epp_ok) begin
        if (epp_go) begin
          launched_reg <= 1'b1;
        end
        if (launched_reg && eng_done_reg) begin
          pready  <= 1'b1;
          pslverr <= eng_tmo_reg;
          prdata  <= DW'(eng_rdata_reg) << {lane, 3'b000};
        end
      end else if (!(is_push && !fifo_in_ready)) begin
        pready  <= 1'b1;
        pslverr <= !hit;
        prdata  <= rd_val;
      end
    end
  end
endmodule

// ---- testbench/ppc_top_checker.sv ----
// Port assertions for the parallel port controller
`timescale 1ns/1ps
module ppc_top_checker (
  input wire logic                   pclk,
  input wire logic                   presetn,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [ppc_pkg::AW-1:0] paddr,
  input wire logic                   pready,
  input wire logic                   pslverr,
  input wire logic                   irq,
  input wire logic                   strobe_n,
  input wire logic [7:0]             pd_out,
  input wire logic                   pd_oe_n
);
  import ppc_pkg::*;
  logic clr_wr;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ============================================================
  // Only a clear or enable write may take the interrupt down
  assign clr_wr = psel && penable && pready && pwrite && (paddr[7:0] == OFS_ICLR || paddr[7:0] == OFS_IEN);
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready longer than one cycle");
  a_ready_cause: assert property ($rose(pready) |-> $past(psel && penable)) else $error("pready without access");
  a_ready_wait: assert property (psel && !penable |=> !pready) else $error("pready in setup phase");
  a_err_ready: assert property (pslverr |-> pready) else $error("pslverr outside ready");
  a_irq_hold: assert property ($rose(irq) |=> irq) else $error("interrupt edge not held");
  a_irq_drop: assert property ($fell(irq) |-> $past(clr_wr) || $past(clr_wr, 2)) else $error("irq fell alone");
  // ============================================================
  // Strobe shape on the port
  a_strobe_len: assert property ($fell(strobe_n) |=> !strobe_n [*8]) else $error("strobe too short");
  a_strobe_data: assert property (!strobe_n && $past(!strobe_n) |-> $stable(pd_out)) else $error("data moved");
  a_strobe_drive: assert property (!strobe_n |-> !pd_oe_n) else $error("strobe with data floating");
endmodule

// ---- testbench/ppc_periph.sv ----
// Behavioural peripheral on the far side of the port pins
`timescale 1ns/1ps
module ppc_periph (
  input  wire logic       pclk,
  input  wire logic       epp,
  input  wire logic [5:0] dly,
  input  wire logic [7:0] rd_byte,
  input  wire logic       strobe_n,
  input  wire logic       autofd_n,
  input  wire logic       selin_n,
  input  wire logic       pd_oe_n,
  output logic            busy,
  output logic            ack_n,
  output logic [7:0]      pd_in
);
  logic       act;
  logic [5:0] cnt;
  assign act = epp ? (!autofd_n || !selin_n) : !strobe_n;
  // Busy follows the active strobe after dly+1 cycles; ack pulses as it drops
  always @(posedge pclk) begin
    ack_n <= !(busy && !act && cnt >= dly);
    if (act == busy)
      cnt <= 6'h00;
    else if (cnt >= dly) begin
      busy <= act;
      cnt  <= 6'h00;
    end else
      cnt <= cnt + 6'h01;
  end
  // Bus shows rd_byte only while released and busy, else the inverse, so a stale byte never passes
  assign pd_in = (pd_oe_n && busy) ? rd_byte : ~rd_byte;
  initial begin
    busy  = 1'b0;
    ack_n = 1'b1;
    cnt   = 6'h00;
  end
endmodule

// ---- testbench/ppc_bench.sv ----
// Self-checking bench of the parallel port controller
`timescale 1ns/1ps
module ppc_bench;
  import ppc_pkg::*;
  logic          pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, dma_req, dma_ack;
  logic          pd_oe_n, strobe_n, autofd_n, init_n, selin_n, ctl_oe_n, ack_n, busy, epp, e;
  logic [AW-1:0] paddr;
  logic [DW-1:0] pwdata, prdata, r, w, seed;
  logic [7:0]    dma_wdata, pd_in, pd_out, rd_byte, cap, b;
  logic [5:0]    dly;
  int            err_count, tests_run, sel_cnt, s0;
  ppc_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq,
    .dma_req, .dma_ack, .dma_wdata, .pd_in, .pd_out, .pd_oe_n, .strobe_n, .autofd_n, .init_n, .selin_n,
    .ctl_oe_n, .ack_n, .busy, .perror(1'b0), .select(1'b1), .fault_n(1'b1));
  ppc_periph u_per (.pclk, .epp, .dly, .rd_byte, .strobe_n, .autofd_n, .selin_n, .pd_oe_n, .busy, .ack_n, .pd_in);
  // ============================================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic ran_out();
    err_count++;
    $display("Error at %0t: wait ran out", $time);
    summarize();
  endtask
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [AW-1:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 3000);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 3000) ran_out();
  endtask
  // Waits for the interrupt or for a strobe, bounded
  task automatic wait_ev(input logic on_irq);
    int n;
    n = 0;
    while ((on_irq ? irq : !strobe_n) !== 1'b1 && n < 2000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 2000) ran_out();
    repeat (3) @(posedge pclk);
  endtask
  task automatic settle();
    repeat (2) @(posedge pclk);
    #1;
  endtask
  // Latch what the port shows while a byte is strobed
  always @(posedge pclk) begin
    if (!strobe_n) cap <= pd_out;
    if (!selin_n) sel_cnt <= sel_cnt + 1;
  end
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // ============================================================
  // Main sequence
  initial begin
    seed = 32'h0001447E;
    {presetn, psel, penable, pwrite, dma_ack, epp} = 6'h00;
    {paddr, pwdata, dma_wdata, rd_byte} = '0;
    dly = 6'h02;
    {err_count, tests_run, sel_cnt} = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, OFS_CFG, 0); chk(r, 32'(CFG_RST));
    apb(0, OFS_CTRL, 0); chk(r[5:0], 32'(CTRL_RST));
    apb(0, 12'h400 | OFS_CFG, 0); chk(e, 1);
    apb(1, OFS_CFG, 32'(CFG_RST) | 32'h4);
    apb(0, 12'h400 | OFS_CFG, 0); chk(e, 0); chk(r, 32'(CFG_RST) | 32'h4);
    apb(1, OFS_CFG, 32'(CFG_RST) & 32'h7E); settle(); chk({ctl_oe_n, pd_oe_n}, 2'b11);
    apb(1, OFS_CFG, 32'(CFG_RST)); settle(); chk({ctl_oe_n, init_n}, 2'b01);
    apb(1, OFS_ECR, 32'({MODE_PFIFO, 5'h00}));
    apb(1, OFS_IEN, 32'h1 << EV_DONE); settle(); chk(dma_req, 1);
    b = 8'(rnd());
    apb(1, OFS_FIFO, {24'h0, b}); wait_ev(1); chk({irq, cap}, {1'b1, b});
    apb(0, OFS_ISTAT, 0); chk(r[EV_DONE], 1);
    apb(1, OFS_IEN, 0); settle(); chk(irq, 0);
    apb(1, OFS_ICLR, 32'hF); apb(0, OFS_ISTAT, 0); chk(r, 0);
    // Slow peripheral fed by a demand DMA push
    apb(1, OFS_IEN, 32'h1 << EV_DONE);
    b = 8'(rnd());
    dly <= 6'h14;
    dma_wdata <= b;
    dma_ack <= 1'b1;
    repeat (4) @(posedge pclk);
    dma_ack <= 1'b0;
    wait_ev(0); chk(cap, b);
    wait_ev(1); chk(irq, 1);
    apb(1, OFS_ICLR, 32'hF);
    epp <= 1'b1;
    dly <= 6'h02;
    apb(1, OFS_ECR, 32'({MODE_EPP, 5'h00}));
    s0 = sel_cnt;
    b = 8'(rnd());
    apb(1, OFS_EPPA, {24'h0, b}); chk({e, cap}, {1'b0, b});
    chk(sel_cnt > s0, 1);
    for (int k = 0; k < 4; k++) begin
      w = rnd();
      apb(1, OFS_EPPD0 + 8'(4 * k), w); chk(cap, w[8*k +: 8]);
      rd_byte <= 8'(rnd());
      dly <= 6'(10 * k + 2);
      apb(0, OFS_EPPD0 + 8'(4 * k), 0); chk({e, r[8*k +: 8]}, {1'b0, rd_byte});
    end
    // Silent peripheral: the EPP cycle must end by timeout with an error
    epp <= 1'b0;
    apb(0, OFS_EPPD0, 0); chk(e, 1);
    apb(0, OFS_STAT, 0); chk(r[0], 1);
    // ECP command byte goes out with autofd held low
    apb(1, OFS_ECR, 32'({MODE_ECP, 5'h00}));
    apb(1, OFS_ICLR, 32'hF);
    b = 8'(rnd());
    apb(1, OFS_AFIFO, {24'h0, b}); wait_ev(0); chk({autofd_n, cap}, {1'b0, b});
    wait_ev(1); chk(irq, 1);
    // Test mode: the FIFO is read back over the bus, no handshake
    apb(1, OFS_ECR, 32'({MODE_TEST, 5'h00}));
    b = 8'(rnd());
    apb(1, OFS_FIFO, {24'h0, b}); apb(0, OFS_FIFO, 0); chk(r, 32'(b));
    apb(0, OFS_FIFO, 0); chk(r, 0);
    // Byte mode with direction set lets go of the data lines
    apb(1, OFS_ECR, 32'({MODE_BYTE, 5'h00})); apb(1, OFS_CTRL, 32'h24); settle(); chk(pd_oe_n, 1);
    summarize();
  end
endmodule
bind ppc_top ppc_top_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pready, .pslverr, .irq,
  .strobe_n, .pd_out, .pd_oe_n);
